// [src/pmt_pkg.sv]
// constants for the period match timer: register map, fields, reset values
// assumes an axi4-lite master with 32-bit data; registers sit in the low byte
//
// Overview of operation
// - eight-bit count register, read/write, cleared by every reset.
// - prescale field: 00 divides by 1, 01 by 4, 1x by 16.
// - count up to the period value, then return to zero on the next tick.
// - eight-bit period register, read/write, resets to all ones.
// - matches feed a four-bit postscaler whose terminal count sets flag bit 1.
// - postscale ratio is the select field plus one, 1 to 16.
// - count write, control write and reset clear prescaler and postscaler.
// - control writes leave the count value unchanged.
// - control bit 2 runs the counter; cleared, the counter stops.
// - control holds postscale 6:3, run bit 2, prescale 1:0, all reset zero.
// - control bit 7 reads zero and ignores writes.
// - raw match pulse, before the postscaler, goes to the serial port.
// - count and match event go to the pwm unit as its time base.
package pmt_pkg;
  // printed offsets are not all multiples of four: these are word indices
  localparam logic [7:0] PMT_IDX_FLAGS = 8'h0c;
  localparam logic [7:0] PMT_IDX_COUNT = 8'h11;
  localparam logic [7:0] PMT_IDX_CONTROL = 8'h12;
  localparam logic [7:0] PMT_IDX_ENABLES = 8'h8c;
  localparam logic [7:0] PMT_IDX_PERIOD = 8'h92;
  localparam int PMT_ADDR_W = 10;
  // field positions
  localparam int PMT_IRQ_BIT = 1;
  localparam int PMT_RUN_BIT = 2;
  localparam int PMT_POST_LSB = 3;
  localparam int PMT_PRE_LSB = 0;
  localparam logic [7:0] PMT_CONTROL_MASK = 8'h7f;
  localparam logic [7:0] PMT_FLAGS_MASK = 8'h02;
  // reset values
  localparam logic [7:0] PMT_COUNT_RST = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RST = 8'hff;
  localparam logic [7:0] PMT_CONTROL_RST = 8'h00;
  localparam logic [7:0] PMT_FLAGS_RST = 8'h00;
  localparam logic [7:0] PMT_ENABLES_RST = 8'h00;
  // instruction clock is the system clock divided by four
  localparam logic [1:0] PMT_INSN_DIV_LAST = 2'h3;
  localparam logic [3:0] PMT_PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PMT_PRE_LAST_16 = 4'hf;
  localparam logic [1:0] PMT_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMT_RESP_SLVERR = 2'h2;
endpackage

// [src/pmt_timer.sv]
// period match timer with prescaler, postscaler and axi4-lite register slave
// assumes a single clock; serial port and pwm consumers sit on the same clock
`timescale 1ns/1ps
module pmt_timer (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // axi4-lite write address and data
  input wire logic [pmt_pkg::PMT_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [pmt_pkg::PMT_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // consumers of the time base
  output logic SERIAL_SHIFT_TICK,
  output logic PWM_MATCH_TICK,
  output logic [7:0] PWM_COUNT,
  output logic IRQ_PENDING
);
  import pmt_pkg::*;

  logic [7:0] count_reg, count_next;
  logic [7:0] period_reg;
  logic [7:0] control_reg;
  logic [7:0] flags_reg;
  logic [7:0] enables_reg;
  logic [1:0] insn_div_reg;
  logic [3:0] pre_cnt_reg;
  logic [3:0] post_cnt_reg;
  logic match_reg, irq_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [PMT_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic awready_reg, wready_reg, arready_reg;

  // write side: latch address and data independently, commit once both held
  wire aw_take = S_AXI_AWVALID && !aw_hold_reg && !bvalid_reg;
  wire w_take = S_AXI_WVALID && !w_hold_reg && !bvalid_reg;
  wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire [7:0] wr_idx = awaddr_reg[PMT_ADDR_W-1:2];
  wire wr_lane0 = wstrb_reg[0];
  wire [7:0] wr_byte = wdata_reg[7:0];
  wire wr_hit_flags = wr_idx == PMT_IDX_FLAGS;
  wire wr_hit_count = wr_idx == PMT_IDX_COUNT;
  wire wr_hit_control = wr_idx == PMT_IDX_CONTROL;
  wire wr_hit_enables = wr_idx == PMT_IDX_ENABLES;
  wire wr_hit_period = wr_idx == PMT_IDX_PERIOD;
  wire wr_mapped = wr_hit_flags | wr_hit_count | wr_hit_control | wr_hit_enables
    | wr_hit_period;
  wire wr_count = wr_fire && wr_hit_count && wr_lane0;
  wire wr_control = wr_fire && wr_hit_control && wr_lane0;
  wire wr_flags = wr_fire && wr_hit_flags && wr_lane0;
  wire wr_enables = wr_fire && wr_hit_enables && wr_lane0;
  wire wr_period = wr_fire && wr_hit_period && wr_lane0;

  // read side decode
  wire ar_take = S_AXI_ARVALID && !rvalid_reg;
  wire [7:0] rd_idx = S_AXI_ARADDR[PMT_ADDR_W-1:2];
  wire rd_hit_flags = rd_idx == PMT_IDX_FLAGS;
  wire rd_hit_count = rd_idx == PMT_IDX_COUNT;
  wire rd_hit_control = rd_idx == PMT_IDX_CONTROL;
  wire rd_hit_enables = rd_idx == PMT_IDX_ENABLES;
  wire rd_hit_period = rd_idx == PMT_IDX_PERIOD;
  wire rd_mapped = rd_hit_flags | rd_hit_count | rd_hit_control | rd_hit_enables
    | rd_hit_period;
  wire [7:0] rd_byte = rd_hit_flags ? flags_reg :
    rd_hit_count ? count_reg :
    rd_hit_control ? (control_reg & PMT_CONTROL_MASK) :
    rd_hit_enables ? enables_reg :
    rd_hit_period ? period_reg : 8'h00;

  // next state of the handshake flags, so that every ready can come from a flop
  // without a cycle of lag against the holding registers it mirrors
  wire aw_hold_next = wr_fire ? 1'b0 : (aw_take ? 1'b1 : aw_hold_reg);
  wire w_hold_next = wr_fire ? 1'b0 : (w_take ? 1'b1 : w_hold_reg);
  wire bvalid_next = wr_fire ? 1'b1 : ((bvalid_reg && S_AXI_BREADY) ? 1'b0 : bvalid_reg);
  wire rvalid_next = ar_take ? 1'b1 : ((rvalid_reg && S_AXI_RREADY) ? 1'b0 : rvalid_reg);

  // control fields
  wire run = control_reg[PMT_RUN_BIT];
  wire [1:0] pre_sel = control_reg[PMT_PRE_LSB +: 2];
  wire [3:0] post_sel = control_reg[PMT_POST_LSB +: 4];

  // prescaler: instruction tick every fourth clock, then 1, 4 or 16
  wire insn_tick = insn_div_reg == PMT_INSN_DIV_LAST;
  wire [3:0] pre_last = pre_sel[1] ? PMT_PRE_LAST_16 :
    (pre_sel[0] ? PMT_PRE_LAST_4 : 4'h0);
  wire inc_tick = run && insn_tick && (pre_cnt_reg == pre_last);
  wire at_period = count_reg == period_reg;
  wire match = inc_tick && at_period;
  wire post_term = match && (post_cnt_reg == post_sel);
  // a count write or a control write clears the prescaler and the postscaler
  wire scaler_clr = wr_count || wr_control;

  // next count: software write wins over the tick in the same cycle
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = wr_byte;
    end else if (inc_tick) begin
      count_next = at_period ? 8'h00 : count_reg + 8'h01;
    end
  end

  // counter, period and scalers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      count_reg <= PMT_COUNT_RST;
      period_reg <= PMT_PERIOD_RST;
      insn_div_reg <= 2'h0;
      pre_cnt_reg <= 4'h0;
      post_cnt_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
      insn_div_reg <= insn_div_reg + 2'h1;
      if (wr_period) begin
        period_reg <= wr_byte;
      end
      if (scaler_clr) begin
        pre_cnt_reg <= 4'h0;
      end else if (run && insn_tick) begin
        pre_cnt_reg <= (pre_cnt_reg == pre_last) ? 4'h0 : pre_cnt_reg + 4'h1;
      end
      if (scaler_clr) begin
        post_cnt_reg <= 4'h0;
      end else if (match) begin
        post_cnt_reg <= post_term ? 4'h0 : post_cnt_reg + 4'h1;
      end
    end
  end

  // control, flag and enable registers; hardware set beats software clear
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      control_reg <= PMT_CONTROL_RST;
      flags_reg <= PMT_FLAGS_RST;
      enables_reg <= PMT_ENABLES_RST;
    end else begin
      if (wr_control) begin
        control_reg <= wr_byte & PMT_CONTROL_MASK;
      end
      if (wr_enables) begin
        enables_reg <= wr_byte & PMT_FLAGS_MASK;
      end
      if (post_term) begin
        flags_reg[PMT_IRQ_BIT] <= 1'b1;
      end else if (wr_flags && !wr_byte[PMT_IRQ_BIT]) begin
        flags_reg[PMT_IRQ_BIT] <= 1'b0;
      end
    end
  end

  // registered outputs for serial port, pwm unit and interrupt line
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      match_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      match_reg <= match;
      irq_reg <= flags_reg[PMT_IRQ_BIT] && enables_reg[PMT_IRQ_BIT];
    end
  end

  // axi write channel holding registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= PMT_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? PMT_RESP_OKAY : PMT_RESP_SLVERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // axi read channel: one cycle from address to data
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= PMT_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_mapped ? PMT_RESP_OKAY : PMT_RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ready flags as flops; they track the hold and valid state one for one,
  // so a master sees the same acceptance window as before, with no comb path
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
    end else begin
      awready_reg <= !aw_hold_next && !bvalid_next;
      wready_reg <= !w_hold_next && !bvalid_next;
      arready_reg <= !rvalid_next;
    end
  end

  // every port below is driven straight from a flop
  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign SERIAL_SHIFT_TICK = match_reg;
  assign PWM_MATCH_TICK = match_reg;
  assign PWM_COUNT = count_reg;
  assign IRQ_PENDING = irq_reg;

  // checks
  a_count_wraps: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (match && !wr_count) |=> count_reg == 8'h00) else $error("no wrap on match");
  a_count_steps: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (inc_tick && !at_period && !wr_count) |=> count_reg == $past(count_reg) + 8'h01)
    else $error("count did not step");
  a_stopped_holds: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!run && !wr_count) |=> $stable(count_reg)) else $error("stopped counter moved");
  a_control_keeps: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (wr_control && !inc_tick) |=> $stable(count_reg)) else $error("control write hit count");
  a_scaler_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    scaler_clr |=> pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0)
    else $error("scalers not cleared");
  a_flag_sets: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    post_term |=> flags_reg[PMT_IRQ_BIT]) else $error("flag not set");
  a_flag_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (flags_reg[PMT_IRQ_BIT] && !wr_flags) |=> flags_reg[PMT_IRQ_BIT])
    else $error("flag dropped alone");
  a_bit7_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !control_reg[7]) else $error("control bit 7 set");
  a_prescale_16: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (inc_tick && pre_sel[1] && !scaler_clr && !wr_control) ##1 (!scaler_clr)[*8]
    |-> !inc_tick) else $error("prescale 16 ticked early");
  a_match_out: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    match |=> SERIAL_SHIFT_TICK && PWM_MATCH_TICK) else $error("match not exported");
  a_period_reset: assert property (@(posedge CLK_SYS)
    !RST_N |=> period_reg == PMT_PERIOD_RST && count_reg == 8'h00)
    else $error("bad reset values");

  // bus handshake: flopped readies must agree with the holding state
  a_awready_track: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    S_AXI_AWREADY == (!aw_hold_reg && !bvalid_reg)) else $error("awready out of step");
  a_wready_track: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    S_AXI_WREADY == (!w_hold_reg && !bvalid_reg)) else $error("wready out of step");
  a_arready_track: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    S_AXI_ARREADY == !rvalid_reg) else $error("arready out of step");
  // answers must stand until the master takes them
  a_bvalid_holds: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rvalid_holds: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (S_AXI_RVALID && !S_AXI_RREADY) |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_rdata_upper: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000) else $error("upper read bits set");
  a_bresp_unmapped: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (wr_fire && !wr_mapped) |=> S_AXI_BRESP == PMT_RESP_SLVERR)
    else $error("unmapped write not refused");

  // count and period writes land as written; control, flag and enable registers load their reset values
  a_count_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr_count |=> count_reg == $past(wr_byte)) else $error("count write lost");
  a_period_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr_period |=> period_reg == $past(wr_byte)) else $error("period write lost");
  a_reset_control: assert property (@(posedge CLK_SYS)
    !RST_N |=> control_reg == PMT_CONTROL_RST && flags_reg == PMT_FLAGS_RST
    && enables_reg == PMT_ENABLES_RST) else $error("bad control reset");

  // prescale spacing: divide by 1 steps every fourth clock, by 4 has no step eight clocks later
  a_prescale_1: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (inc_tick && pre_sel == 2'b00) ##1 (run && !scaler_clr)[*3] |=> inc_tick)
    else $error("prescale 1 missed a tick");
  a_prescale_4: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (inc_tick && pre_sel == 2'b01) ##1 (run && !scaler_clr)[*8] |-> !inc_tick)
    else $error("prescale 4 ticked early");

  // postscaler and flag: only a terminal count may raise the flag
  a_post_bound: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    post_cnt_reg <= post_sel) else $error("postscaler overran select");
  a_flag_needs_term: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!flags_reg[PMT_IRQ_BIT] && !post_term) |=> !flags_reg[PMT_IRQ_BIT])
    else $error("flag rose without terminal count");
  a_irq_follows: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (flags_reg[PMT_IRQ_BIT] && enables_reg[PMT_IRQ_BIT]) |=> IRQ_PENDING)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !enables_reg[PMT_IRQ_BIT] |=> !IRQ_PENDING) else $error("masked interrupt raised");
  // the shift clock is a single-cycle pulse; a stretched one would double-shift
  a_shift_single: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SERIAL_SHIFT_TICK |=> !SERIAL_SHIFT_TICK) else $error("shift tick stretched");

  // main scenarios worth seeing at least once
  c_match: cover property (@(posedge CLK_SYS) disable iff (!RST_N) match);
  c_prescale_16: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    inc_tick && pre_sel == 2'b11);
  c_post_term: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    post_term && post_sel == 4'hf);
  c_set_clear: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    post_term && wr_flags && !wr_byte[PMT_IRQ_BIT]);
  c_irq: cover property (@(posedge CLK_SYS) disable iff (!RST_N) IRQ_PENDING);
endmodule

// [test/pmt_testbench.sv]
// self-checking bench for the period match timer, driven over axi4-lite
// assumes pmt_timer and pmt_pkg from src/; the assertions live in the design
`timescale 1ns/1ps
module testbench;
  import pmt_pkg::*;
  logic CLK_SYS, RST_N;
  logic [PMT_ADDR_W-1:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic shift_tick, pwm, irq;
  logic [7:0] pcnt;
  logic [31:0] d;
  int error_cnt, samples_checked;
  localparam logic [9:0] A_FLG = {PMT_IDX_FLAGS, 2'b00};
  localparam logic [9:0] A_CNT = {PMT_IDX_COUNT, 2'b00};
  localparam logic [9:0] A_CTL = {PMT_IDX_CONTROL, 2'b00};
  localparam logic [9:0] A_ENA = {PMT_IDX_ENABLES, 2'b00};
  localparam logic [9:0] A_PER = {PMT_IDX_PERIOD, 2'b00};

  pmt_timer uut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .SERIAL_SHIFT_TICK(shift_tick), .PWM_MATCH_TICK(pwm),
    .PWM_COUNT(pcnt), .IRQ_PENDING(irq));

  // 4 ns clock
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write; entered just after a rising edge, returns at the response edge;
  // handshakes are judged on settled values before the edge, bready stays high
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    int t;
    logic aw_ok, w_ok, b_ok;
    t = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0000_00, v};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge CLK_SYS);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid === 1'b1;
      r = bresp;
      @(posedge CLK_SYS);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      t++;
    end while (!b_ok && t < 200);
    if (t >= 200) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [9:0] a);
    int t;
    logic ar_ok, r_ok;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge CLK_SYS);
      ar_ok = arvalid && arready;
      r_ok = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge CLK_SYS);
      if (ar_ok) arvalid <= 1'b0;
      t++;
    end while (!r_ok && t < 200);
    if (t >= 200) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    rd(a);
    chk(d, {24'h0000_00, exp});
    chk({30'h0, r}, {30'h0, PMT_RESP_OKAY});
  endtask

  // clocks between two match pulses, and the highest count seen between them
  task automatic gap(input logic [1:0] pre, input logic [7:0] per, input int exp);
    int n;
    logic [7:0] mx;
    wr(A_CTL, 8'h00);
    wr(A_PER, per);
    wr(A_CNT, 8'h00);
    wr(A_CTL, {5'h00, 1'b1, pre});
    n = 0;
    mx = 8'h00;
    do begin
      @(negedge CLK_SYS);
      n++;
    end while (shift_tick !== 1'b1 && n < 2000);
    chk({31'h0, pwm}, 32'h1);
    n = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
      if (pcnt > mx) mx = pcnt;
    end while (shift_tick !== 1'b1 && n < 2000);
    chk(n, exp);
    chk({24'h0, mx}, {24'h0, per});
    @(posedge CLK_SYS);
  endtask

  // matches counted from a fresh postscaler up to the pending interrupt
  task automatic post(input logic [3:0] sel);
    int n;
    int t;
    wr(A_CTL, 8'h00);
    wr(A_FLG, 8'h00);
    wr(A_CNT, 8'h00);
    wr(A_CTL, {1'b0, sel, 3'b100});
    n = 0;
    t = 0;
    while (irq !== 1'b1 && t < 3000) begin
      @(negedge CLK_SYS);
      if (shift_tick === 1'b1) n++;
      t++;
    end
    chk(n, sel + 1);
    @(posedge CLK_SYS);
    wr(A_CTL, 8'h00);
    repeat (40) @(posedge CLK_SYS);
    rchk(A_FLG, PMT_FLAGS_MASK);
    wr(A_FLG, 8'h00);
    rchk(A_FLG, 8'h00);
    repeat (2) @(posedge CLK_SYS);
    chk({31'h0, irq}, 32'h0);
  endtask

  // watchdog sized well above the longest expected run
  initial begin
    repeat (40000) @(posedge CLK_SYS);
    error_cnt++;
    finish_test();
  end

  initial begin
    RST_N = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    error_cnt = 0;
    samples_checked = 0;
    repeat (20) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    rchk(A_CNT, 8'h00);
    rchk(A_PER, 8'hff);
    rchk(A_CTL, 8'h00);
    rchk(A_FLG, 8'h00);
    rchk(A_ENA, 8'h00);
    rd(10'h000);
    chk({30'h0, r}, {30'h0, PMT_RESP_SLVERR});
    wr(10'h000, 8'h55);
    chk({30'h0, r}, {30'h0, PMT_RESP_SLVERR});
    wr(A_CTL, 8'hff);
    rchk(A_CTL, 8'h7f);
    wr(A_CTL, 8'h00);
    wr(A_CNT, 8'h5a);
    rchk(A_CNT, 8'h5a);
    wr(A_CTL, 8'h7b);
    rchk(A_CNT, 8'h5a);
    repeat (50) @(posedge CLK_SYS);
    rchk(A_CNT, 8'h5a);
    wr(A_PER, 8'h3c);
    rchk(A_PER, 8'h3c);
    // every prescale code, and the period boundary of zero
    gap(2'b00, 8'h03, 16);
    gap(2'b01, 8'h03, 64);
    gap(2'b10, 8'h03, 256);
    gap(2'b11, 8'h03, 256);
    gap(2'b00, 8'h00, 4);
    wr(A_ENA, 8'h02);
    post(4'h0);
    post(4'h1);
    post(4'hf);
    finish_test();
  end
endmodule
